// *** rtl/pwm_timer_pkg.sv ***
package pwm_timer_pkg;
  // ----------------------------------------------------------------
  // Register map (byte addresses on APB)
  // ----------------------------------------------------------------
  localparam logic [7:0] ctrl_a_addr = 8'h00;
  localparam logic [7:0] ctrl_b_addr = 8'h04;
  localparam logic [7:0] cmp_a_addr = 8'h08;
  localparam logic [7:0] cmp_b_addr = 8'h0c;
  localparam logic [7:0] count_addr = 8'h10;
  localparam logic [7:0] flags_addr = 8'h14;
  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int mode_a_hi = 7;
  localparam int mode_a_lo = 6;
  localparam int mode_b_hi = 5;
  localparam int mode_b_lo = 4;
  localparam int wsel_hi = 1;
  localparam int wsel_lo = 0;
  localparam int wsel_top_pos = 3;
  localparam int presc_hi = 2;
  localparam int presc_lo = 0;
  localparam int async_pos = 4;
  localparam int ovf_pos = 0;
  localparam int cmpa_pos = 1;
  localparam int cmpb_pos = 2;
  localparam int dir_a_pos = 8;
  localparam int dir_b_pos = 9;
  localparam logic [7:0] ctrl_a_reset = 8'h00;
  localparam logic [7:0] ctrl_a_wmask = 8'hf3;
  localparam logic [7:0] ctrl_b_wmask = 8'h1f;
  localparam logic [7:0] ctrl_reset = 8'h00;
  localparam logic [7:0] cnt_bottom = 8'h00;
  localparam logic [7:0] cnt_max = 8'hff;
  localparam int period_ticks = 510;
  // ----------------------------------------------------------------
  // Modes and prescaler
  // ----------------------------------------------------------------
  localparam logic [2:0] wsel_normal = 3'h0;
  localparam logic [2:0] wsel_pc_ff = 3'h1;
  localparam logic [2:0] wsel_ctc = 3'h2;
  localparam logic [2:0] wsel_fast_ff = 3'h3;
  localparam logic [2:0] wsel_pc_ocra = 3'h5;
  localparam logic [2:0] wsel_fast_ocra = 3'h7;
  localparam logic [1:0] om_off = 2'h0;
  localparam logic [1:0] om_toggle = 2'h1;
  localparam logic [1:0] om_clear = 2'h2;
  localparam logic [1:0] om_set = 2'h3;
  localparam logic [9:0] div_8 = 10'h007;
  localparam logic [9:0] div_32 = 10'h01f;
  localparam logic [9:0] div_64 = 10'h03f;
  localparam logic [9:0] div_128 = 10'h07f;
  localparam logic [9:0] div_256 = 10'h0ff;
  localparam logic [9:0] div_1024 = 10'h3ff;
  typedef enum logic [1:0] {
    dir_up_st = 2'b01,
    dir_down_st = 2'b10
  } dir_type;
endpackage

// *** rtl/timer8_phase_correct_pwm.sv ***
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/100ps
// Function
// - Fast PWM toggle mode inverts on match
// - Waveform select 1 or 5 is phase correct
// - Count up to TOP, then down
// - TOP is 0xFF or compare value A
// - Clear on up match, set on down
// - Mode two non-inverted, three inverted
// - Hold TOP one tick, then reverse
// - Overflow flag set at BOTTOM
// - Period spans 510 timer ticks with TOP 0xFF, twice compare A when TOP is compare A
// - Prescale 1,8,32,64,128,256,1024
// - Compare at BOTTOM or MAX gives constant
// - Leaving MAX applies down-count match level
// - Missed down match fixed at BOTTOM
// - Tick is enable; async uses oscillator tick
// - Control A field layout, reserved zero
// - Nonzero mode overrides pin if output
// - Non-PWM mode encodes match action
// - PWM toggle needs top select bit
// - Select from control A plus B
module timer8_phase_correct_pwm (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic osc_tick_in,
  input wire logic port_data_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic pin_a_out,
  output logic pin_a_oe_n_out,
  output logic pin_b_out,
  output logic pin_b_oe_n_out,
  output logic overflow_flag_out
);
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] ctrl_a_ff, nxt_ctrl_a;
  logic [7:0] ctrl_b_ff, nxt_ctrl_b;
  logic [7:0] buf_a_ff, nxt_buf_a, buf_b_ff, nxt_buf_b;
  logic [7:0] cmp_a_ff, nxt_cmp_a, cmp_b_ff, nxt_cmp_b;
  logic [7:0] cnt_ff, nxt_cnt;
  logic [9:0] pre_ff, nxt_pre;
  logic [2:0] flags_ff, nxt_flags;
  logic [1:0] oc_ff, nxt_oc;
  logic [31:0] prdata_ff, nxt_prdata;
  logic pready_ff, nxt_pready, pslverr_ff, nxt_pslverr;
  logic pin_a_ff, pin_b_ff, oe_a_n_ff, oe_b_n_ff;
  logic nxt_pin_a, nxt_pin_b, nxt_oe_a_n, nxt_oe_b_n;
  logic [7:0] port_dir_ff, nxt_port_dir;
  pwm_timer_pkg::dir_type dir_ff, nxt_dir;

  logic [2:0] wsel;
  logic pc_mode, fast_mode, pwm_mode, tick, at_top, pc_dn_now;
  logic [7:0] top_val;
  logic wr_en, rd_en;
  logic [1:0] match;

  assign wsel = {ctrl_b_ff[pwm_timer_pkg::wsel_top_pos],
                 ctrl_a_ff[pwm_timer_pkg::wsel_hi:pwm_timer_pkg::wsel_lo]};
  assign pc_mode = (wsel == pwm_timer_pkg::wsel_pc_ff) ||
                   (wsel == pwm_timer_pkg::wsel_pc_ocra);
  assign fast_mode = (wsel == pwm_timer_pkg::wsel_fast_ff) ||
                     (wsel == pwm_timer_pkg::wsel_fast_ocra);
  assign pwm_mode = pc_mode || fast_mode;
  assign top_val = (wsel[2] || wsel == pwm_timer_pkg::wsel_ctc) ?
                   cmp_a_ff : pwm_timer_pkg::cnt_max;
  assign at_top = (cnt_ff == top_val);
  assign pc_dn_now = (dir_ff == pwm_timer_pkg::dir_down_st);
  assign wr_en = psel_in && penable_in && pwrite_in && !pready_ff;
  assign rd_en = psel_in && penable_in && !pwrite_in && !pready_ff;

  // ----------------------------------------------------------------
  // Timer tick: prescaled I/O clock or oscillator tick
  // ----------------------------------------------------------------
  always_comb begin
    unique case (ctrl_b_ff[pwm_timer_pkg::presc_hi:pwm_timer_pkg::presc_lo])
      3'h1: tick = 1'b1;
      3'h2: tick = ((pre_ff & pwm_timer_pkg::div_8) == pwm_timer_pkg::div_8);
      3'h3: tick = ((pre_ff & pwm_timer_pkg::div_32) == pwm_timer_pkg::div_32);
      3'h4: tick = ((pre_ff & pwm_timer_pkg::div_64) == pwm_timer_pkg::div_64);
      3'h5: tick = ((pre_ff & pwm_timer_pkg::div_128) == pwm_timer_pkg::div_128);
      3'h6: tick = ((pre_ff & pwm_timer_pkg::div_256) == pwm_timer_pkg::div_256);
      3'h7: tick = (pre_ff == pwm_timer_pkg::div_1024);
      default: tick = 1'b0;
    endcase
    // Async source counts oscillator ticks instead of I/O cycles
    if (ctrl_b_ff[pwm_timer_pkg::async_pos] &&
        ctrl_b_ff[pwm_timer_pkg::presc_hi:pwm_timer_pkg::presc_lo] != 3'h0) begin
      tick = osc_tick_in;
    end
  end

  // ----------------------------------------------------------------
  // Counter, direction, compare buffer, output
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_match
      assign match[gi] = (cnt_ff == (gi == 0 ? cmp_a_ff : cmp_b_ff));
    end
  endgenerate

  always_comb begin
    logic [1:0] mode;
    logic [7:0] cmp;
    mode = 2'h0;
    cmp = 8'h00;
    nxt_pre = pre_ff + 10'h001;
    nxt_cnt = cnt_ff;
    nxt_dir = dir_ff;
    nxt_cmp_a = cmp_a_ff;
    nxt_cmp_b = cmp_b_ff;
    nxt_oc = oc_ff;
    // Write one to clear first; hardware sets are ORed in below, so they win
    nxt_flags = flags_ff;
    if (wr_en && paddr_in == pwm_timer_pkg::flags_addr) begin
      nxt_flags = flags_ff & ~pwdata_in[2:0];
    end
    if (!pwm_mode) begin
      nxt_cmp_a = buf_a_ff;
      nxt_cmp_b = buf_b_ff;
    end
    if (tick) begin
      if (pc_mode) begin
        if (at_top) begin
          nxt_dir = pwm_timer_pkg::dir_down_st;
          nxt_cnt = cnt_ff - 8'h01;
          nxt_cmp_a = buf_a_ff;
          nxt_cmp_b = buf_b_ff;
        end else if (cnt_ff == pwm_timer_pkg::cnt_bottom) begin
          nxt_dir = pwm_timer_pkg::dir_up_st;
          nxt_cnt = cnt_ff + 8'h01;
        end else if (pc_dn_now) begin
          nxt_cnt = cnt_ff - 8'h01;
        end else begin
          nxt_cnt = cnt_ff + 8'h01;
        end
        if (nxt_cnt == pwm_timer_pkg::cnt_bottom) begin
          nxt_flags[pwm_timer_pkg::ovf_pos] = 1'b1;
        end
      end else if (at_top && wsel != pwm_timer_pkg::wsel_normal) begin
        nxt_cnt = pwm_timer_pkg::cnt_bottom;
        if (fast_mode) begin
          nxt_cmp_a = buf_a_ff;
          nxt_cmp_b = buf_b_ff;
          nxt_flags[pwm_timer_pkg::ovf_pos] = 1'b1;
        end
      end else begin
        nxt_cnt = cnt_ff + 8'h01;
        if (cnt_ff == pwm_timer_pkg::cnt_max) begin
          nxt_flags[pwm_timer_pkg::ovf_pos] = 1'b1;
        end
      end
      for (int i = 0; i < 2; i++) begin
        mode = (i == 0) ? ctrl_a_ff[pwm_timer_pkg::mode_a_hi:pwm_timer_pkg::mode_a_lo] :
                          ctrl_a_ff[pwm_timer_pkg::mode_b_hi:pwm_timer_pkg::mode_b_lo];
        cmp = (i == 0) ? cmp_a_ff : cmp_b_ff;
        if (match[i]) begin
          nxt_flags[pwm_timer_pkg::cmpa_pos + i] = 1'b1;
        end
        if (!pwm_mode) begin
          if (match[i]) begin
            case (mode)
              pwm_timer_pkg::om_toggle: nxt_oc[i] = !oc_ff[i];
              pwm_timer_pkg::om_clear: nxt_oc[i] = 1'b0;
              pwm_timer_pkg::om_set: nxt_oc[i] = 1'b1;
              default: nxt_oc[i] = oc_ff[i];
            endcase
          end
        end else if (mode == pwm_timer_pkg::om_toggle) begin
          // Only channel A can toggle; B's code is reserved
          if (i == 0 && wsel[2] && match[i]) begin
            nxt_oc[i] = !oc_ff[i];
          end
        end else if (mode[1]) begin
          if (pc_mode) begin
            if (at_top && cmp == pwm_timer_pkg::cnt_max) begin
              nxt_oc[i] = !mode[0];
            end else if (match[i] && !(at_top && cmp == top_val)) begin
              // A match at BOTTOM counts as up-going, so compare zero keeps the up level
              nxt_oc[i] = (pc_dn_now && cnt_ff != pwm_timer_pkg::cnt_bottom) ?
                          !mode[0] : mode[0];
            end else if (cnt_ff == pwm_timer_pkg::cnt_bottom &&
                         cmp != pwm_timer_pkg::cnt_max) begin
              // Bottom edge restores the down-count match level (symmetry)
              nxt_oc[i] = !mode[0];
            end
          end else if (at_top) begin
            nxt_oc[i] = (cmp == top_val) ? mode[0] : !mode[0];
          end else if (match[i]) begin
            nxt_oc[i] = mode[0];
          end
        end
      end
    end
    if (wr_en && paddr_in == pwm_timer_pkg::count_addr) begin
      nxt_cnt = pwdata_in[7:0];
    end
  end


  // ----------------------------------------------------------------
  // APB slave and pin drive
  // ----------------------------------------------------------------
  always_comb begin
    nxt_ctrl_a = ctrl_a_ff;
    nxt_ctrl_b = ctrl_b_ff;
    nxt_buf_a = buf_a_ff;
    nxt_buf_b = buf_b_ff;
    nxt_port_dir = port_dir_ff;
    nxt_prdata = prdata_ff;
    nxt_pslverr = 1'b0;
    nxt_pready = psel_in && penable_in && !pready_ff;
    if (wr_en) begin
      case (paddr_in)
        pwm_timer_pkg::ctrl_a_addr: nxt_ctrl_a = pwdata_in[7:0] & pwm_timer_pkg::ctrl_a_wmask;
        pwm_timer_pkg::ctrl_b_addr: begin
          nxt_ctrl_b = pwdata_in[7:0] & pwm_timer_pkg::ctrl_b_wmask;
          nxt_port_dir = {6'h00, pwdata_in[pwm_timer_pkg::dir_b_pos],
                          pwdata_in[pwm_timer_pkg::dir_a_pos]};
        end
        pwm_timer_pkg::cmp_a_addr: nxt_buf_a = pwdata_in[7:0];
        pwm_timer_pkg::cmp_b_addr: nxt_buf_b = pwdata_in[7:0];
        pwm_timer_pkg::count_addr, pwm_timer_pkg::flags_addr: nxt_pslverr = 1'b0;
        default: nxt_pslverr = 1'b1;
      endcase
    end
    if (rd_en) begin
      case (paddr_in)
        pwm_timer_pkg::ctrl_a_addr: nxt_prdata = {24'h000000, ctrl_a_ff};
        pwm_timer_pkg::ctrl_b_addr: nxt_prdata = {22'h000000, port_dir_ff[1:0], ctrl_b_ff};
        pwm_timer_pkg::cmp_a_addr: nxt_prdata = {24'h000000, buf_a_ff};
        pwm_timer_pkg::cmp_b_addr: nxt_prdata = {24'h000000, buf_b_ff};
        pwm_timer_pkg::count_addr: nxt_prdata = {24'h000000, cnt_ff};
        pwm_timer_pkg::flags_addr: nxt_prdata = {29'h00000000, flags_ff};
        default: begin
          nxt_prdata = 32'h00000000;
          nxt_pslverr = 1'b1;
        end
      endcase
    end
    // Pin value taken over whenever mode is active; drive enable follows direction alone
    nxt_pin_a = (ctrl_a_ff[7:6] != pwm_timer_pkg::om_off) ? oc_ff[0] : port_data_in;
    nxt_pin_b = (ctrl_a_ff[5:4] != pwm_timer_pkg::om_off) ? oc_ff[1] : port_data_in;
    if (pwm_mode && !wsel[2] && ctrl_a_ff[7:6] == pwm_timer_pkg::om_toggle) begin
      nxt_pin_a = port_data_in;
    end
    nxt_oe_a_n = !port_dir_ff[0];
    nxt_oe_b_n = !port_dir_ff[1];
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      ctrl_a_ff <= pwm_timer_pkg::ctrl_a_reset;
      ctrl_b_ff <= pwm_timer_pkg::ctrl_reset;
      buf_a_ff <= 8'h00;
      buf_b_ff <= 8'h00;
      cmp_a_ff <= 8'h00;
      cmp_b_ff <= 8'h00;
      cnt_ff <= pwm_timer_pkg::cnt_bottom;
      pre_ff <= 10'h000;
      dir_ff <= pwm_timer_pkg::dir_up_st;
      flags_ff <= 3'h0;
      oc_ff <= 2'h0;
      port_dir_ff <= 8'h00;
      prdata_ff <= 32'h00000000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      pin_a_ff <= 1'b0;
      pin_b_ff <= 1'b0;
      oe_a_n_ff <= 1'b1;
      oe_b_n_ff <= 1'b1;
    end else begin
      ctrl_a_ff <= nxt_ctrl_a;
      ctrl_b_ff <= nxt_ctrl_b;
      buf_a_ff <= nxt_buf_a;
      buf_b_ff <= nxt_buf_b;
      cmp_a_ff <= nxt_cmp_a;
      cmp_b_ff <= nxt_cmp_b;
      cnt_ff <= nxt_cnt;
      pre_ff <= nxt_pre;
      dir_ff <= nxt_dir;
      flags_ff <= nxt_flags;
      oc_ff <= nxt_oc;
      port_dir_ff <= nxt_port_dir;
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      pin_a_ff <= nxt_pin_a;
      pin_b_ff <= nxt_pin_b;
      oe_a_n_ff <= nxt_oe_a_n;
      oe_b_n_ff <= nxt_oe_b_n;
    end
  end

  assign prdata_out = prdata_ff;
  assign pready_out = pready_ff;
  assign pslverr_out = pslverr_ff;
  assign pin_a_out = pin_a_ff;
  assign pin_b_out = pin_b_ff;
  assign pin_a_oe_n_out = oe_a_n_ff;
  assign pin_b_oe_n_out = oe_b_n_ff;
  assign overflow_flag_out = flags_ff[pwm_timer_pkg::ovf_pos];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  top_turn_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    tick && pc_mode && at_top |=> dir_ff == pwm_timer_pkg::dir_down_st)
    else $error("direction did not turn at top");
  bottom_ovf_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    tick && pc_mode && cnt_ff == 8'h01 && pc_dn_now |=> flags_ff[0])
    else $error("overflow flag not set at bottom");
  pc_step_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    tick && pc_mode && !at_top && cnt_ff != 8'h00 && !pc_dn_now && !wr_en
    |=> cnt_ff == $past(cnt_ff) + 8'h01)
    else $error("up count did not step");
  reserved_zero_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    ctrl_a_ff[3:2] == 2'h0)
    else $error("reserved bits not zero");
  oe_follow_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    ##1 pin_a_oe_n_out == !$past(port_dir_ff[0]))
    else $error("pin enable not following direction");
  buf_hold_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    pwm_mode && !(tick && at_top) |=> $stable(cmp_a_ff))
    else $error("compare changed mid period");
  ack_one_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    pready_out |=> !pready_out)
    else $error("ready held too long");
  up_clear_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    tick && pc_mode && !pc_dn_now && match[0] && !at_top && cmp_a_ff != 8'h00
    && ctrl_a_ff[7:6] == pwm_timer_pkg::om_clear |=> !oc_ff[0])
    else $error("up match did not clear output");
endmodule // timer8_phase_correct_pwm

// *** bench/timer8_phase_correct_pwm_test.sv ***
`timescale 1ns/100ps
module timer8_phase_correct_pwm_test;
  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  localparam int limit = 30000;
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic psel_in = 1'b0;
  logic penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic [7:0] paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0000_0000;
  logic osc_tick_in = 1'b0;
  logic port_data_in = 1'b0;
  logic [31:0] prdata_out;
  logic pready_out, pslverr_out, pin_a_out, pin_a_oe_n_out;
  logic pin_b_out, pin_b_oe_n_out, overflow_flag_out;
  int mismatches = 0;
  int checks_done = 0;
  int tick_cnt = 0;
  int cyc = 0;
  int w;
  logic [31:0] rd;
  logic err;
  always #20 clk_in = ~clk_in;
  // Oscillator stand-in: one tick every fourth clock, so async widths scale by 4
  always @(posedge clk_in) begin
    tick_cnt <= (tick_cnt == 3) ? 0 : tick_cnt + 1;
    osc_tick_in <= (tick_cnt == 3);
    cyc <= cyc + 1;
  end
  timer8_phase_correct_pwm uut (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .osc_tick_in(osc_tick_in), .port_data_in(port_data_in),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .pin_a_out(pin_a_out), .pin_a_oe_n_out(pin_a_oe_n_out), .pin_b_out(pin_b_out),
    .pin_b_oe_n_out(pin_b_oe_n_out), .overflow_flag_out(overflow_flag_out)
  );
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Entered just after a rising edge; leaves one idle edge so psel is never set twice
  task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel_in <= 1'b1;
    pwrite_in <= wr_en;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready_out !== 1'b1 && n < 20);
    if (pready_out !== 1'b1) begin
      chk("apb answer", 1, 0);
      wrap_up();
    end
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input string name, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(name, exp, rd);
  endtask
  function automatic logic [31:0] ca(input logic [1:0] mode, input logic [1:0] wlow);
    return {24'h00_0000, mode, 4'h0, wlow};
  endfunction
  function automatic logic [31:0] cb(input logic [2:0] p, input logic top, input logic as,
                                     input logic dir);
    return {29'h0000_0000, p} | ({31'h0, top} << pwm_timer_pkg::wsel_top_pos)
      | ({31'h0, as} << pwm_timer_pkg::async_pos) | ({31'h0, dir} << pwm_timer_pkg::dir_a_pos);
  endfunction
  // Measures a whole stretch at level v; earlier stretches may be cut by mode changes
  task automatic width(input logic v, input int reps, output int n);
    int k;
    k = 0;
    repeat (reps) begin
      while (pin_a_out !== ~v && k < limit) begin @(posedge clk_in); k++; end
      while (pin_a_out !== v && k < limit) begin @(posedge clk_in); k++; end
      n = 0;
      while (pin_a_out === v && k < limit) begin @(posedge clk_in); k++; n++; end
    end
    if (k >= limit) begin
      chk("pin edge wait", 0, 1);
      wrap_up();
    end
  endtask
  task automatic hold(input logic v, input int cycles);
    int bad;
    bad = 0;
    repeat (cycles) begin
      @(posedge clk_in);
      if (pin_a_out !== v) bad++;
    end
    chk("pin off level cycles", 0, 32'(bad));
  endtask
  task automatic ovf_rise;
    int k;
    k = 0;
    while (overflow_flag_out !== 1'b1 && k < limit) begin @(posedge clk_in); k++; end
    if (k >= limit) begin
      chk("overflow wait", 0, 1);
      wrap_up();
    end
  endtask
  task automatic ovf_gap(output int n);
    int t1;
    wr(pwm_timer_pkg::flags_addr, 32'h1);
    ovf_rise();
    t1 = cyc;
    wr(pwm_timer_pkg::flags_addr, 32'h1);
    chk("overflow cleared", 0, {31'h0, overflow_flag_out});
    ovf_rise();
    n = cyc - t1;
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (100000) @(posedge clk_in);
    chk("run time limit", 0, 1);
    wrap_up();
  end
  initial begin
    repeat (3) @(posedge clk_in);
    reset_n_in <= 1'b1;
    @(posedge clk_in);
    rdc("ctrl a reset", pwm_timer_pkg::ctrl_a_addr, 32'h0000_0000);
    wr(pwm_timer_pkg::ctrl_a_addr, 32'h0000_00ff);
    rdc("ctrl a mask", pwm_timer_pkg::ctrl_a_addr, 32'h0000_00f3);
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk("unmapped error", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    wr(pwm_timer_pkg::cmp_a_addr, 32'h0);
    wr(pwm_timer_pkg::ctrl_a_addr, ca(pwm_timer_pkg::om_clear, 2'h1));
    wr(pwm_timer_pkg::ctrl_b_addr, cb(3'h1, 1'b0, 1'b0, 1'b1));
    // A new compare value loads at TOP and acts a period later: allow two periods
    repeat (1100) @(posedge clk_in);
    hold(1'b0, 520);
    wr(pwm_timer_pkg::cmp_a_addr, 32'hff);
    repeat (1100) @(posedge clk_in);
    hold(1'b1, 520);
    wr(pwm_timer_pkg::cmp_a_addr, 32'h80);
    width(1'b0, 1, w);
    chk("low width", 254, w);
    width(1'b1, 1, w);
    chk("high width", 256, w);
    chk("drive enable", 0, {31'h0, pin_a_oe_n_out});
    wr(pwm_timer_pkg::ctrl_b_addr, cb(3'h1, 1'b0, 1'b0, 1'b0));
    repeat (3) @(posedge clk_in);
    chk("drive off", 1, {31'h0, pin_a_oe_n_out});
    chk("pin b drive off", 1, {31'h0, pin_b_oe_n_out});
    wr(pwm_timer_pkg::ctrl_b_addr, cb(3'h1, 1'b0, 1'b0, 1'b1));
    wr(pwm_timer_pkg::ctrl_a_addr, ca(pwm_timer_pkg::om_set, 2'h1));
    width(1'b1, 2, w);
    chk("inverted high width", 254, w);
    ovf_gap(w);
    chk("overflow gap", 510, w);
    wr(pwm_timer_pkg::ctrl_a_addr, ca(pwm_timer_pkg::om_clear, 2'h1));
    for (int i = 0; i < 2; i++) begin
      wr(pwm_timer_pkg::ctrl_b_addr, cb(3'(i + 2), 1'b0, 1'b0, 1'b1));
      // The stretch cut by the change is skipped; one full stretch keeps /32 inside the limit
      width(1'b0, 1, w);
      chk("prescaled low width", 32'(254 * (i == 0 ? 8 : 32)), w);
    end
    wr(pwm_timer_pkg::ctrl_b_addr, cb(3'h1, 1'b0, 1'b1, 1'b1));
    width(1'b0, 2, w);
    chk("osc tick low width", 32'(254 * 4), w);
    wr(pwm_timer_pkg::cmp_a_addr, 32'h40);
    wr(pwm_timer_pkg::ctrl_b_addr, cb(3'h1, 1'b1, 1'b0, 1'b1));
    ovf_gap(w);
    ovf_gap(w);
    chk("compare top gap", 128, w);
    wr(pwm_timer_pkg::cmp_a_addr, 32'h0f);
    wr(pwm_timer_pkg::ctrl_a_addr, ca(pwm_timer_pkg::om_toggle, 2'h3));
    width(1'b1, 2, w);
    chk("fast toggle width", 16, w);
    wr(pwm_timer_pkg::ctrl_a_addr, ca(pwm_timer_pkg::om_toggle, 2'h1));
    wr(pwm_timer_pkg::ctrl_b_addr, cb(3'h1, 1'b0, 1'b0, 1'b1));
    port_data_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    chk("port level high", 1, {31'h0, pin_a_out});
    chk("pin b port level", 1, {31'h0, pin_b_out});
    port_data_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    chk("port level low", 0, {31'h0, pin_a_out});
    wr(pwm_timer_pkg::ctrl_a_addr, ca(pwm_timer_pkg::om_toggle, 2'h2));
    width(1'b1, 2, w);
    chk("match toggle width", 16, w);
    wr(pwm_timer_pkg::ctrl_a_addr, ca(pwm_timer_pkg::om_clear, 2'h2));
    repeat (40) @(posedge clk_in);
    hold(1'b0, 40);
    wr(pwm_timer_pkg::ctrl_a_addr, ca(pwm_timer_pkg::om_set, 2'h2));
    repeat (40) @(posedge clk_in);
    hold(1'b1, 40);
    wr(pwm_timer_pkg::ctrl_a_addr, ca(pwm_timer_pkg::om_off, 2'h2));
    repeat (4) @(posedge clk_in);
    chk("disconnected level", 0, {31'h0, pin_a_out});
    wrap_up();
  end
endmodule // timer8_phase_correct_pwm_test
